// >>> acc_defines.svh
// register map, field positions and conversion counts
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_ADDR_W         3
`define ACC_OFS_INPUT_SEL  3'h0
`define ACC_OFS_CTRL_STAT  3'h1
`define ACC_OFS_RES_LOW    3'h2
`define ACC_OFS_RES_HIGH   3'h3
`define ACC_OFS_TRIG_MISC  3'h4
`define ACC_CS_ENABLE      7
`define ACC_CS_START       6
`define ACC_CS_ATE         5
`define ACC_CS_FLAG        4
`define ACC_CS_IE          3
`define ACC_IS_REF_LO      6
`define ACC_IS_LADJ        5
`define ACC_TS_LO          5
`define ACC_TS_RESV        4
`define ACC_RST_BYTE       8'h00
`define ACC_FIRST_CYCLES   5'd25
`define ACC_NORMAL_CYCLES  5'd13
`define ACC_CODE_BANDGAP   5'h1e
`define ACC_CODE_GROUND    5'h1f
`endif

// >>> acc_pkg.sv
// types shared by the conversion control block
package acc_pkg;
	typedef enum logic [2:0] {
		ACC_ST_OFF  = 3'b001,
		ACC_ST_IDLE = 3'b010,
		ACC_ST_CONV = 3'b100
	} acc_state_t;
	typedef enum logic [1:0] {
		ACC_GAIN_1X   = 2'h0,
		ACC_GAIN_10X  = 2'h1,
		ACC_GAIN_200X = 2'h2
	} acc_gain_t;
	typedef enum logic [2:0] {
		ACC_TRIG_FREE = 3'h0,
		ACC_TRIG_ACMP = 3'h1,
		ACC_TRIG_EXT0 = 3'h2,
		ACC_TRIG_T0CM = 3'h3,
		ACC_TRIG_T0OV = 3'h4,
		ACC_TRIG_T1CB = 3'h5,
		ACC_TRIG_T1OV = 3'h6,
		ACC_TRIG_T1CP = 3'h7
	} acc_trig_t;
endpackage

// >>> acc_prescaler.sv
// converter clock divider: 2,2,4,...,128 from the system clock
module acc_prescaler #(
	parameter int CNT_W = 7
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       run,
	input  wire logic [2:0] div_sel,
	output logic            tick_q,
	output logic            adc_clk_q
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] half_m1;
	logic [CNT_W-1:0] last;
	logic [2:0]       shift;

	always_comb begin
		shift   = (div_sel == 3'h0) ? 3'h1 : div_sel; // R12
		half_m1 = CNT_W'((1 << (shift - 3'h1)) - 1);
		last    = {half_m1[CNT_W-2:0], 1'b1};
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst || !run) begin
			cnt_q     <= '0;
			tick_q    <= 1'b0;
			adc_clk_q <= 1'b0;
		end else if (cnt_q >= last) begin
			cnt_q     <= '0;
			tick_q    <= 1'b1;
			adc_clk_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 1'b1;
			tick_q <= 1'b0;
			if (cnt_q == half_m1) begin
				adc_clk_q <= 1'b0;
			end
		end
	end
endmodule

// >>> acc_core.sv
// converter control: registers, start logic, timing, result
//
// Overview of operation
// [R1] new input selection during a conversion applies only after it completes
// [R2] codes 00000-00111 single inputs 0-7, 11110 bandgap, 11111 ground
// [R3] 01xxx differential with gain 10x/200x, 10000-11101 differential 1x
// [R4] enable one powers converter, zero powers off and aborts conversion
// [R5] start write begins one conversion, in free running only the first
// [R6] first conversion after enable takes 25 converter cycles, later 13
// [R7] start bit reads one while converting, writing zero does nothing
// [R8] auto trigger starts a conversion on rising edge of trigger
// [R9] completion flag sets when conversion ends and result is stored
// [R10] flag clears when vector taken or software writes one to it
// [R11] interrupt request needs flag, irq enable and global enable
// [R12] divide field picks 2,2,4,8,16,32,64,128 for converter clock
// [R13] right adjusted result in bits 9:0, upper six read zero
// [R14] left adjusted result in bits 15:6, lower six read zero
// [R15] reading low byte blocks result updates until high byte read
// [R16] software reads low before high, or only high for 8 bits
// [R17] differential results are presented in two's complement
// [R18] trigger source field acts only while auto trigger enabled
// [R19] source 0 free running, 1-7 comparator, ext0, timer events
// [R20] switching to a set source from a clear one is an edge
// [R21] switching to free running never makes a trigger event
// [R22] reserved bit 4 of trigger register reads zero, ignores writes
// [R23] left adjust change alters result presentation at once
// [R24] reference change during conversion applies after it completes
// [R25] free running restarts on rising edge of completion flag
//
// Our own choices: the register offsets and strobed register access.
`include "acc_defines.svh"

module acc_core (
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	input  wire logic [`ACC_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata_q,
	input  wire logic                   vector_taken,
	input  wire logic                   global_irq_en,
	input  wire logic [6:0]             trig_flags,
	input  wire logic [9:0]             core_result,
	output logic                        irq_q,
	output logic                        adc_clk_q,
	output logic                        core_power_q,
	output logic                        core_busy_q,
	output logic                        core_init_q,
	output logic      [4:0]             core_channel_q,
	output logic      [1:0]             core_ref_q,
	output logic                        core_diff_q,
	output logic      [2:0]             core_pos_q,
	output logic      [2:0]             core_neg_q,
	output acc_pkg::acc_gain_t          core_gain_q,
	output logic                        core_bandgap_q,
	output logic                        core_ground_q
);
	acc_pkg::acc_state_t state_q;
	logic [7:0] input_sel_q;
	logic       en_q;
	logic       ate_q;
	logic       flag_q;
	logic       ie_q;
	logic [2:0] div_q;
	logic [2:0] ts_q;
	logic [2:0] ts_prev_q;
	logic       trig_prev_q;
	logic [4:0] cnt_q;
	logic [4:0] last_q;
	logic       init_pend_q;
	logic [9:0] result_q;
	logic       lock_q;
	logic       tick_q;
	logic       wr_is;
	logic       wr_cs;
	logic       wr_ts;
	logic       rd_lo;
	logic       rd_hi;
	logic       sw_start;
	logic       trig_now;
	logic       auto_edge;
	logic       start;
	logic       done;
	logic       conv;
	logic [15:0] res16;
	logic [4:0] sel;

	////////////////////////////////////////////////////////////////
	// strobes and decode

	always_comb begin
		wr_is = reg_wr && (reg_addr == `ACC_OFS_INPUT_SEL);
		wr_cs = reg_wr && (reg_addr == `ACC_OFS_CTRL_STAT);
		wr_ts = reg_wr && (reg_addr == `ACC_OFS_TRIG_MISC);
		rd_lo = reg_rd && (reg_addr == `ACC_OFS_RES_LOW);
		rd_hi = reg_rd && (reg_addr == `ACC_OFS_RES_HIGH);
		conv  = (state_q == acc_pkg::ACC_ST_CONV);
		sel   = input_sel_q[4:0];
	end

	////////////////////////////////////////////////////////////////
	// start sources

	always_comb begin
		sw_start = wr_cs && reg_wdata[`ACC_CS_ENABLE]
			&& reg_wdata[`ACC_CS_START]; // R5
		if (ts_q == acc_pkg::ACC_TRIG_FREE) begin
			trig_now = flag_q; // R25
		end else begin
			trig_now = trig_flags[3'(ts_q - 3'h1)]; // R19
		end
		auto_edge = ate_q && trig_now && !trig_prev_q // R8 R18 R20
			&& !(ts_q == 3'h0 && ts_prev_q != 3'h0); // R21
		start = (sw_start && !conv)
			|| (auto_edge && state_q == acc_pkg::ACC_ST_IDLE);
		done  = conv && tick_q && (cnt_q == last_q);
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			trig_prev_q <= 1'b0;
			ts_prev_q   <= 3'h0;
		end else begin
			trig_prev_q <= trig_now;
			ts_prev_q   <= ts_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// conversion sequencer

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_q <= acc_pkg::ACC_ST_OFF;
		end else if (wr_cs && !reg_wdata[`ACC_CS_ENABLE]) begin
			state_q <= acc_pkg::ACC_ST_OFF; // R4
		end else begin
			case (state_q)
				acc_pkg::ACC_ST_OFF: begin
					if (start) begin
						state_q <= acc_pkg::ACC_ST_CONV;
					end else if (wr_cs) begin
						state_q <= acc_pkg::ACC_ST_IDLE; // R4
					end
				end
				acc_pkg::ACC_ST_IDLE: begin
					if (start) begin
						state_q <= acc_pkg::ACC_ST_CONV;
					end
				end
				acc_pkg::ACC_ST_CONV: begin
					if (done) begin
						state_q <= acc_pkg::ACC_ST_IDLE;
					end
				end
				default: state_q <= acc_pkg::ACC_ST_OFF;
			endcase
		end
	end

	// count converter clock periods of the running conversion
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cnt_q       <= 5'h0;
			last_q      <= 5'h0;
			init_pend_q <= 1'b1;
		end else if (state_q == acc_pkg::ACC_ST_OFF && !start) begin
			cnt_q       <= 5'h0;
			init_pend_q <= 1'b1;
		end else if (start) begin
			cnt_q       <= 5'h0;
			init_pend_q <= 1'b0;
			last_q      <= init_pend_q ? `ACC_FIRST_CYCLES - 5'd1
				: `ACC_NORMAL_CYCLES - 5'd1; // R6
		end else if (conv && tick_q) begin
			cnt_q <= cnt_q + 5'd1;
		end
	end

	acc_prescaler #(
		.CNT_W (7)
	) u_prescaler (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.run       (en_q),
		.div_sel   (div_q), // R12
		.tick_q    (tick_q),
		.adc_clk_q (adc_clk_q)
	);

	////////////////////////////////////////////////////////////////
	// software registers

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			input_sel_q <= `ACC_RST_BYTE;
			en_q        <= 1'b0;
			ate_q       <= 1'b0;
			ie_q        <= 1'b0;
			div_q       <= 3'h0;
			ts_q        <= 3'h0;
		end else begin
			if (wr_is) begin
				input_sel_q <= reg_wdata;
			end
			if (wr_cs) begin
				en_q  <= reg_wdata[`ACC_CS_ENABLE]; // R4
				ate_q <= reg_wdata[`ACC_CS_ATE];
				ie_q  <= reg_wdata[`ACC_CS_IE];
				div_q <= reg_wdata[2:0];
			end
			if (wr_ts) begin
				ts_q <= reg_wdata[7:`ACC_TS_LO]; // R22
			end
		end
	end

	// completion flag, a new completion beats a clear
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			flag_q <= 1'b0;
		end else if (done) begin
			flag_q <= 1'b1; // R9
		end else if (vector_taken
			|| (wr_cs && reg_wdata[`ACC_CS_FLAG])) begin
			flag_q <= 1'b0; // R10
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_q && ie_q && global_irq_en; // R11
		end
	end

	////////////////////////////////////////////////////////////////
	// result store and read lock

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			result_q <= 10'h000;
		end else if (done && !lock_q) begin // R15
			result_q <= core_diff_q ? {~core_result[9], core_result[8:0]}
				: core_result; // R17
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lock_q <= 1'b0;
		end else if (rd_hi) begin
			lock_q <= 1'b0; // R15 R16
		end else if (rd_lo) begin
			lock_q <= 1'b1; // R15
		end
	end

	always_comb begin
		if (input_sel_q[`ACC_IS_LADJ]) begin
			res16 = {result_q, 6'h00}; // R14 R23
		end else begin
			res16 = {6'h00, result_q}; // R13
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			reg_rdata_q <= `ACC_RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				`ACC_OFS_INPUT_SEL: reg_rdata_q <= input_sel_q;
				`ACC_OFS_CTRL_STAT: reg_rdata_q <= {en_q, conv, ate_q,
					flag_q, ie_q, div_q}; // R7
				`ACC_OFS_RES_LOW:   reg_rdata_q <= res16[7:0];
				`ACC_OFS_RES_HIGH:  reg_rdata_q <= res16[15:8];
				`ACC_OFS_TRIG_MISC: reg_rdata_q <= {ts_q, 5'h00}; // R22
				default:            reg_rdata_q <= 8'h00;
			endcase
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// analog core controls, selection frozen while converting

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			core_power_q <= 1'b0;
			core_busy_q  <= 1'b0;
			core_init_q  <= 1'b0;
		end else begin
			core_power_q <= en_q;
			core_busy_q  <= conv;
			core_init_q  <= conv && (last_q == `ACC_FIRST_CYCLES - 5'd1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			core_channel_q <= 5'h00;
			core_ref_q     <= 2'h0;
			core_diff_q    <= 1'b0;
			core_pos_q     <= 3'h0;
			core_neg_q     <= 3'h0;
			core_gain_q    <= acc_pkg::ACC_GAIN_1X;
			core_bandgap_q <= 1'b0;
			core_ground_q  <= 1'b0;
		end else if (!conv) begin // R1 R24
			core_channel_q <= sel;
			core_ref_q     <= input_sel_q[7:`ACC_IS_REF_LO];
			core_bandgap_q <= (sel == `ACC_CODE_BANDGAP); // R2
			core_ground_q  <= (sel == `ACC_CODE_GROUND); // R2
			core_pos_q     <= sel[2:0];
			core_neg_q     <= 3'h0;
			core_gain_q    <= acc_pkg::ACC_GAIN_1X;
			core_diff_q    <= 1'b1;
			case (sel[4:3])
				2'b00: core_diff_q <= 1'b0; // R2
				2'b01: begin // R3
					core_pos_q  <= {1'b0, sel[2], sel[0]};
					core_neg_q  <= {1'b0, sel[2], 1'b0};
					core_gain_q <= sel[1] ? acc_pkg::ACC_GAIN_200X
						: acc_pkg::ACC_GAIN_10X;
				end
				2'b10: core_neg_q <= 3'h1; // R3
				default: begin
					core_neg_q  <= 3'h2; // R3
					core_diff_q <= (sel[2:1] != 2'b11);
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	default clocking acc_cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	sequence acc_seq_sw_start;
		sw_start && !conv;
	endsequence

	sequence acc_seq_done;
		done;
	endsequence

	sequence acc_seq_free_done;
		acc_seq_done ##0 (ate_q && ts_q == 3'h0 && !flag_q && !reg_wr);
	endsequence

	AST_START_BUSY: assert property (acc_seq_sw_start |=> conv // R5
		&& cnt_q == 5'h0)
		else $error("start write did not begin a conversion");

	AST_ABORT: assert property ((wr_cs && !reg_wdata[`ACC_CS_ENABLE]) // R4
		|=> state_q == acc_pkg::ACC_ST_OFF ##1 !core_busy_q)
		else $error("disable did not abort conversion");

	AST_FLAG_SET: assert property (acc_seq_done |=> flag_q // R9
		&& (state_q == acc_pkg::ACC_ST_IDLE || !en_q))
		else $error("flag not set at completion");

	AST_W1C: assert property ((wr_cs && reg_wdata[`ACC_CS_FLAG] // R10
		&& !done) |=> !flag_q)
		else $error("flag did not clear on write of one");

	AST_IRQ: assert property (irq_q |-> $past(flag_q) // R11
		&& $past(ie_q) && $past(global_irq_en))
		else $error("interrupt raised without its conditions");

	AST_LOCK_HOLD: assert property ((done && lock_q) // R15
		|=> $stable(result_q))
		else $error("result updated while locked");

	AST_SEL_HOLD: assert property ((conv && $past(conv)) // R1
		|-> $stable(core_channel_q) && $stable(core_ref_q))
		else $error("selection changed during conversion");

	AST_RESV: assert property ((reg_rd && reg_addr == `ACC_OFS_TRIG_MISC)
		|=> reg_rdata_q[`ACC_TS_RESV:0] == 5'h00) // R22
		else $error("reserved bit read nonzero");

	AST_LEFT: assert property ((rd_hi && input_sel_q[`ACC_IS_LADJ]) // R14
		|=> reg_rdata_q == $past(result_q[9:2]))
		else $error("left adjusted high byte wrong");

	AST_RIGHT: assert property ((rd_hi && !input_sel_q[`ACC_IS_LADJ]) // R13
		|=> reg_rdata_q[7:2] == 6'h00)
		else $error("right adjusted high bits not zero");

	AST_FREE_RUN: assert property ((acc_seq_free_done ##1 !reg_wr[*2]) // R25
		|-> conv)
		else $error("free running did not restart");
endmodule

// >>> acc_analog_model.sv
// stand-in for the analog sampling core and the trigger sources
module acc_analog_model (
	input  wire logic       ref_clk,
	input  wire logic       core_power_q,
	input  wire logic [9:0] level,
	input  wire logic [6:0] flags_in,
	output logic      [9:0] core_result,
	output logic      [6:0] trig_flags
);
	timeunit 1ns;
	timeprecision 1ns;
	// unpowered core shows the inverse, never a held value
	assign core_result = core_power_q ? level : ~level;
	assign trig_flags  = flags_in;
endmodule

// >>> tb_acc_core.sv
// self-checking bench for the conversion control block
`include "acc_defines.svh"
module tb_acc_core;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [2:0] SEL = `ACC_OFS_INPUT_SEL;
	localparam logic [2:0] CS  = `ACC_OFS_CTRL_STAT;
	localparam logic [2:0] RL  = `ACC_OFS_RES_LOW;
	localparam logic [2:0] RH  = `ACC_OFS_RES_HIGH;
	localparam logic [2:0] TM  = `ACC_OFS_TRIG_MISC;
	logic               ref_clk, nrst, reg_wr, reg_rd, la;
	logic [2:0]         reg_addr;
	logic [7:0]         reg_wdata, reg_rdata_q, d, e;
	logic               vector_taken, global_irq_en;
	logic [6:0]         trig_flags, flags_in;
	logic [9:0]         core_result, level;
	logic               irq_q, adc_clk_q, core_power_q, core_busy_q;
	logic               core_init_q, core_diff_q, core_bandgap_q;
	logic               core_ground_q;
	logic [4:0]         core_channel_q, c;
	logic [1:0]         core_ref_q, rf;
	logic [2:0]         core_pos_q, core_neg_q;
	acc_pkg::acc_gain_t core_gain_q;
	logic [15:0]        res;
	int                 errors, n_checks, seed, n;

	acc_core u_dut (
		.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .vector_taken(vector_taken),
		.global_irq_en(global_irq_en), .trig_flags(trig_flags),
		.core_result(core_result), .irq_q(irq_q), .adc_clk_q(adc_clk_q),
		.core_power_q(core_power_q), .core_busy_q(core_busy_q),
		.core_init_q(core_init_q), .core_channel_q(core_channel_q),
		.core_ref_q(core_ref_q), .core_diff_q(core_diff_q),
		.core_pos_q(core_pos_q), .core_neg_q(core_neg_q),
		.core_gain_q(core_gain_q), .core_bandgap_q(core_bandgap_q),
		.core_ground_q(core_ground_q)
	);
	acc_analog_model u_model (
		.ref_clk(ref_clk), .core_power_q(core_power_q), .level(level),
		.flags_in(flags_in), .core_result(core_result),
		.trig_flags(trig_flags)
	);

	////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] divf(input logic [2:0] k);
		return (k < 3'h2) ? 8'h02 : 8'h01 << k;
	endfunction
	function automatic logic dif(input logic [4:0] k);
		return k >= 5'h08 && k <= 5'h1d;
	endfunction
	function automatic logic [5:0] pn(input logic [4:0] k);
		if (k < 5'h10)
			return {1'b0, k[2], k[0], 1'b0, k[2], 1'b0};
		return {k[2:0], k[3] ? 3'h2 : 3'h1};
	endfunction
	// expected {high, low} pair
	function automatic logic [15:0] pres(input logic [9:0] r,
		input logic l, input logic df);
		logic [9:0] v;
		v = df ? r ^ 10'h200 : r;
		return l ? {v, 6'h00} : {6'h00, v};
	endfunction

	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		v = reg_rdata_q;
	endtask
	// busy cycles of one conversion
	task automatic run(output int len);
		len = 0;
		for (int i = 0; i < 8 && core_busy_q !== 1'b1; i++)
			@(posedge ref_clk);
		while (core_busy_q === 1'b1 && len < 400) begin
			@(posedge ref_clk);
			len++;
		end
	endtask
	task automatic conv(input int cyc);
		run(n);
		chk(n >= 2 * cyc - 4 && n <= 2 * cyc + 1, 1'b1);
	endtask
	task automatic rise(output int m);
		m = 0;
		while (adc_clk_q !== 1'b0 && m < 300) begin
			@(posedge ref_clk);
			m++;
		end
		while (adc_clk_q !== 1'b1 && m < 300) begin
			@(posedge ref_clk);
			m++;
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		seed = 83989;
		errors = 0;
		n_checks = 0;
		nrst = 1'b0;
		{reg_wr, reg_rd, vector_taken, global_irq_en} = 4'h0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		flags_in = 7'h00;
		level = 10'h000;
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		wr(3'h5, 8'hff);
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), d);
			chk(d, `ACC_RST_BYTE);
		end
		wr(TM, 8'hff);
		rd(TM, d);
		chk(d, 8'he0);
		for (int k = 0; k < 8; k++) begin
			wr(CS, 8'h80 | 8'(k));
			rise(n);
			rise(n);
			chk(16'(n), 16'(divf(3'(k))));
		end
		for (int i = 0; i < 32; i++) begin
			c = 5'(i);
			rf = 2'($random(seed));
			wr(SEL, {rf, 1'b0, c});
			repeat (2) @(posedge ref_clk);
			chk({core_ref_q, core_channel_q}, {rf, c});
			chk({core_bandgap_q, core_ground_q}, {c == 5'h1e, c == 5'h1f});
			chk(core_diff_q, dif(c));
			if (dif(c)) begin
				chk(core_gain_q, c > 5'h0f ? acc_pkg::ACC_GAIN_1X : c[1] ?
					acc_pkg::ACC_GAIN_200X : acc_pkg::ACC_GAIN_10X);
				chk({core_pos_q, core_neg_q}, pn(c));
			end
		end
		wr(CS, 8'h00);
		for (int i = 0; i < 6; i++) begin
			level <= 10'($random(seed));
			c = (i % 2) ? 5'h10 + 5'(i) : 5'(i);
			la = 1'($random(seed));
			wr(SEL, {2'h0, la, c});
			wr(CS, 8'hd0);
			@(posedge ref_clk);
			chk(core_init_q, i == 0);
			conv(i == 0 ? 25 : 13);
			rd(CS, d);
			chk(d, 8'h90);
			rd(RL, d);
			rd(RH, e);
			chk({e, d}, pres(level, la, dif(c)));
		end
		wr(SEL, {2'h0, ~la, c});
		rd(RL, d);
		rd(RH, e);
		res = pres(level, ~la, dif(c));
		chk({e, d}, res);
		rd(RL, d);
		level <= ~level;
		wr(CS, 8'hd0);
		conv(13);
		rd(RH, e);
		chk(e, res[15:8]);
		wr(CS, 8'hd0);
		conv(13);
		rd(RL, d);
		rd(RH, e);
		chk({e, d}, pres(level, ~la, dif(c)));
		global_irq_en <= 1'b1;
		wr(CS, 8'h88);
		repeat (2) @(posedge ref_clk);
		chk(irq_q, 1'b1);
		global_irq_en <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk(irq_q, 1'b0);
		global_irq_en <= 1'b1;
		vector_taken <= 1'b1;
		@(posedge ref_clk);
		vector_taken <= 1'b0;
		rd(CS, d);
		chk(d, 8'h88);
		chk(irq_q, 1'b0);
		wr(CS, 8'hc8);
		conv(13);
		wr(CS, 8'h98);
		rd(CS, d);
		chk(d, 8'h88);
		global_irq_en <= 1'b0;
		wr(CS, 8'hc0);
		wr(SEL, 8'h1f);
		chk(core_channel_q, c);
		wr(CS, 8'h80);
		rd(CS, d);
		chk(d, 8'hc0);
		run(n);
		repeat (2) @(posedge ref_clk);
		chk(core_channel_q, 5'h1f);
		wr(CS, 8'hd0);
		wr(CS, 8'h00);
		repeat (2) @(posedge ref_clk);
		chk({core_power_q, core_busy_q}, 2'h0);
		wr(CS, 8'hc0);
		conv(25);
		wr(CS, 8'h90);
		for (int s = 1; s < 8; s++) begin
			wr(TM, {3'(s), 5'h00});
			wr(CS, 8'hb0);
			flags_in <= ~(7'h01 << (s - 1));
			repeat (4) @(posedge ref_clk);
			chk(core_busy_q, 1'b0);
			flags_in <= 7'h7f;
			conv(13);
			flags_in <= 7'h00;
		end
		wr(TM, 8'h20);
		flags_in <= 7'h02;
		wr(CS, 8'hb0);
		chk(core_busy_q, 1'b0);
		wr(TM, 8'h40);
		conv(13);
		wr(CS, 8'h90);
		flags_in <= 7'h00;
		@(posedge ref_clk);
		flags_in <= 7'h7f;
		repeat (4) @(posedge ref_clk);
		chk(core_busy_q, 1'b0);
		flags_in <= 7'h00;
		wr(TM, 8'h00);
		wr(CS, 8'hf0);
		run(n);
		conv(13);
		wr(TM, 8'h20);
		wr(TM, 8'h00);
		repeat (4) @(posedge ref_clk);
		chk(core_busy_q, 1'b0);
		wrap_up();
	end
endmodule
